// ===== rtl/lfs_regs.vh
// Register map, field positions and timing constants of the fault and shutdown block
`ifndef LFS_REGS_VH
`define LFS_REGS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LFS_A_STATUS      8'h6E
`define LFS_A_PART_ID     8'h86
`define LFS_A_DIE_REV     8'h87
`define LFS_A_OUT_CFG     8'h89
`define LFS_A_BUS_ADDR    8'h8C
`define LFS_A_SHIFT_HI    8'h8E
`define LFS_A_SHIFT_LO    8'h8F
`define LFS_A_FMASK_LO    8'h90
`define LFS_A_FMASK_HI    8'h91
`define LFS_A_SMASK_LO    8'h92
`define LFS_A_SMASK_HI    8'h93
`define LFS_A_TRAP_LO     8'h94
`define LFS_A_TRAP_HI     8'h95

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LFS_B_NOT_READY   0
`define LFS_B_SHUT_POL    0
`define LFS_B_FLT_LATCH   1
`define LFS_B_FLT_CLEAR   2
`define LFS_B_SOFT_DIS    3
`define LFS_B_BIAS_LIMIT  8
`define LFS_B_SHUT_ALARM  9
`define LFS_B_VCC_LOW     1

// ---------------------------------------------------------------
// Channels, values and timing
// ---------------------------------------------------------------
`define LFS_CH_VCC        3'h1
`define LFS_CH_MONITOR_INPUT_1       3'h2
`define LFS_BUS_ADDR_DEF  8'hA2
`define LFS_BLANK_UPDATES 4'h9
`define LFS_CLK_HZ        10000000
`define LFS_RDY_TIME_US   500
`define LFS_RDY_CYCLES    (`LFS_RDY_TIME_US * (`LFS_CLK_HZ / 1000000))
`define LFS_RDY_MARGIN    13'h0004

`endif

// ===== rtl/lfs_shift.v
// Right shifter for one monitor conversion result
`timescale 1ns/1ps
module lfs_shift #(
   parameter W = 16
) (
   input wire [W-1:0] data_i,
   input wire [2:0] amount_i,
   output wire [W-1:0] data_o
);
   assign data_o = data_i >> amount_i;
endmodule

// ===== rtl/lfs_top.v
// Fault output, safety shutdown, alarm trap and supply supervision logic
`timescale 1ns/1ps
`include "lfs_regs.vh"
module lfs_top #(
   parameter W = 16,
   parameter RDY_CYCLES = `LFS_RDY_CYCLES,
   parameter [7:0] PART_ID = 8'h5A,
   parameter [7:0] DIE_REV = 8'h01,
   parameter [7:0] NV_OUT_CFG = 8'h00,
   parameter [7:0] NV_BUS_ADDR = 8'hA2,
   parameter [7:0] NV_SHIFT_HI = 8'h00,
   parameter [7:0] NV_SHIFT_LO = 8'h00,
   parameter [9:0] NV_FMASK = 10'h000,
   parameter [8:0] NV_SMASK = 9'h000
) (
   input wire clock_i,
   input wire nrst_i,
   input wire analog_power_ok_i,
   input wire tx_disable_pin_i,
   input wire adc_valid_i,
   input wire [2:0] adc_chan_i,
   input wire [W-1:0] adc_raw_i,
   input wire [W-1:0] vcc_low_limit_i,
   input wire [4:0] adc_alarm_i,
   input wire [3:0] quick_trip_i,
   input wire bias_update_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   output reg meas_valid_o,
   output reg [2:0] meas_chan_o,
   output reg [W-1:0] meas_data_o,
   output reg tx_fault_o,
   output reg safety_shutdown_out_o,
   output reg safety_shutdown_oe_o,
   output reg laser_swing_en_o,
   output reg bias_en_o,
   output reg bias_oe_o,
   output reg [7:0] bus_dev_addr_o
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   reg poa_meta_ff, poa_ff, dis_meta_ff, dis_ff;
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         poa_meta_ff <= 1'b0;
         poa_ff <= 1'b0;
         dis_meta_ff <= 1'b1;
         dis_ff <= 1'b1;
      end else begin
         poa_meta_ff <= analog_power_ok_i;
         poa_ff <= poa_meta_ff;
         dis_meta_ff <= tx_disable_pin_i;
         dis_ff <= dis_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Volatile copies of the nonvolatile settings
   // ---------------------------------------------------------------
   reg recalled_ff;
   reg [7:0] out_cfg_ff, bus_addr_ff, shift_hi_ff, shift_lo_ff;
   reg [9:0] fmask_ff;
   reg [8:0] smask_ff;
   reg [9:0] trap_ff;
   reg [12:0] rdy_cnt_ff;
   reg not_ready_ff;
   wire soft_dis = out_cfg_ff[`LFS_B_SOFT_DIS];
   wire disable_any = dis_ff | soft_dis;
   wire wr_cfg = reg_wr_i && (reg_addr_i == `LFS_A_OUT_CFG);
   wire flt_clear = wr_cfg && reg_wdata_i[`LFS_B_FLT_CLEAR];

   // Digital reset forces all cells low; recall happens once per reset
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         recalled_ff <= 1'b0;
         out_cfg_ff <= 8'h00;
         bus_addr_ff <= 8'h00;
         shift_hi_ff <= 8'h00;
         shift_lo_ff <= 8'h00;
         fmask_ff <= 10'h000;
         smask_ff <= 9'h000;
      end else if (poa_ff && !recalled_ff) begin
         recalled_ff <= 1'b1;
         out_cfg_ff <= NV_OUT_CFG;
         bus_addr_ff <= NV_BUS_ADDR;
         shift_hi_ff <= NV_SHIFT_HI;
         shift_lo_ff <= NV_SHIFT_LO;
         fmask_ff <= NV_FMASK;
         smask_ff <= NV_SMASK;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            // Clear bit is a strobe and never stored
            `LFS_A_OUT_CFG: begin
               out_cfg_ff <= reg_wdata_i & ~(8'h01 << `LFS_B_FLT_CLEAR);
            end
            `LFS_A_BUS_ADDR: bus_addr_ff <= reg_wdata_i;
            `LFS_A_SHIFT_HI: shift_hi_ff <= reg_wdata_i;
            `LFS_A_SHIFT_LO: shift_lo_ff <= reg_wdata_i;
            `LFS_A_FMASK_LO: fmask_ff[7:0] <= reg_wdata_i;
            `LFS_A_FMASK_HI: fmask_ff[9:8] <= reg_wdata_i[1:0];
            `LFS_A_SMASK_LO: smask_ff[7:0] <= reg_wdata_i;
            `LFS_A_SMASK_HI: smask_ff[8] <= reg_wdata_i[0];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Monitor right shift
   // ---------------------------------------------------------------
   wire [8:0] shamt_all = {shift_hi_ff[6:4], shift_hi_ff[2:0], shift_lo_ff[6:4]};
   wire [W-1:0] shifted [0:2];
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_mon
         lfs_shift #(.W(W)) u_shift (
            .data_i(adc_raw_i),
            .amount_i(shamt_all[8-3*g -: 3]),
            .data_o(shifted[g])
         );
      end
   endgenerate

   wire [2:0] mon_idx = adc_chan_i - `LFS_CH_MONITOR_INPUT_1;
   wire is_mon = (adc_chan_i >= `LFS_CH_MONITOR_INPUT_1) && (mon_idx < 3'h3);
   wire [W-1:0] nxt_meas = is_mon ? shifted[mon_idx[1:0]] : adc_raw_i;

   // Shifted value feeds only the measurement register; the supply comparator uses the raw value
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         meas_valid_o <= 1'b0;
         meas_chan_o <= 3'h0;
         meas_data_o <= {W{1'b0}};
      end else begin
         meas_valid_o <= adc_valid_i;
         if (adc_valid_i) begin
            meas_chan_o <= adc_chan_i;
            meas_data_o <= nxt_meas;
         end
      end
   end

   // ---------------------------------------------------------------
   // Supply-low alarm and power-up sequencing
   // ---------------------------------------------------------------
   reg vcc_low_ff;
   reg out_en_ff;
   reg [3:0] blank_cnt_ff;
   reg shut_ff;
   wire vcc_ok_conv = adc_valid_i && (adc_chan_i == `LFS_CH_VCC) && (adc_raw_i > vcc_low_limit_i);
   wire nxt_out_en = poa_ff && recalled_ff && !disable_any && !shut_ff && !vcc_low_ff;
   wire reinit = nxt_out_en && !out_en_ff;
   wire blanking = blank_cnt_ff < `LFS_BLANK_UPDATES;

   always @(posedge clock_i) begin
      if (!nrst_i) begin
         vcc_low_ff <= 1'b1;
         out_en_ff <= 1'b0;
         blank_cnt_ff <= 4'h0;
      end else begin
         // Asserting wins over a clearing conversion
         if (!poa_ff) begin
            vcc_low_ff <= 1'b1;
         end else if (vcc_ok_conv) begin
            vcc_low_ff <= 1'b0;
         end
         out_en_ff <= nxt_out_en;
         if (reinit) begin
            blank_cnt_ff <= 4'h0;
         end else if (bias_update_i && blanking) begin
            blank_cnt_ff <= blank_cnt_ff + 4'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Alarm vector
   // ---------------------------------------------------------------
   // Bits 4:2 and 0 ADC, 1 supply low, 8:5 quick trip (8 is bias limit), 9 shutdown
   reg [8:0] alarm_ff;
   wire [8:0] raw_alarm = {quick_trip_i, adc_alarm_i[4:2], vcc_low_ff, adc_alarm_i[0]};
   wire [8:0] blank_mask = blanking ? (9'h001 << `LFS_B_BIAS_LIMIT) : 9'h1FF;
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         alarm_ff <= 9'h000;
      end else if (reinit) begin
         alarm_ff <= raw_alarm & (9'h001 << `LFS_B_VCC_LOW);
      end else begin
         alarm_ff <= raw_alarm & (blank_mask | (9'h001 << `LFS_B_VCC_LOW));
      end
   end

   // ---------------------------------------------------------------
   // Safety shutdown latch
   // ---------------------------------------------------------------
   // Supply-low blocks the latch so slow ramps do not trip it
   wire shut_trip = poa_ff && !vcc_low_ff && |(alarm_ff & smask_ff);
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         shut_ff <= 1'b0;
      end else if (disable_any) begin
         shut_ff <= 1'b0;
      end else if (shut_trip) begin
         shut_ff <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Transmit fault
   // ---------------------------------------------------------------
   reg flt_latch_ff;
   wire [9:0] fault_src = {shut_ff, alarm_ff};
   wire fault_cond = |(fault_src & fmask_ff);
   wire latch_en = out_cfg_ff[`LFS_B_FLT_LATCH];
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         flt_latch_ff <= 1'b0;
      end else if (flt_clear || disable_any) begin
         flt_latch_ff <= 1'b0;
      end else if (latch_en && fault_cond && !vcc_low_ff) begin
         flt_latch_ff <= 1'b1;
      end
   end

   // Shutdown bit persists in the source, so clear alone cannot drop it
   reg nxt_fault;
   always @* begin
      if (!poa_ff) begin
         nxt_fault = 1'b1;
      end else if (disable_any) begin
         nxt_fault = 1'b0;
      end else begin
         nxt_fault = fault_cond | flt_latch_ff;
      end
   end

   // ---------------------------------------------------------------
   // Traps and readiness
   // ---------------------------------------------------------------
   wire [9:0] trap_set = {shut_ff, raw_alarm};
   wire wr_trap_lo = reg_wr_i && (reg_addr_i == `LFS_A_TRAP_LO);
   wire wr_trap_hi = reg_wr_i && (reg_addr_i == `LFS_A_TRAP_HI);
   wire [9:0] trap_keep = {wr_trap_hi ? reg_wdata_i[1:0] : 2'b11, wr_trap_lo ? reg_wdata_i : 8'hFF};
   // Margin covers the input sync so the bit clears inside the window
   wire rdy_more = (rdy_cnt_ff + `LFS_RDY_MARGIN) < RDY_CYCLES[12:0];
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         trap_ff <= 10'h000;
         rdy_cnt_ff <= 13'h0000;
         not_ready_ff <= 1'b1;
      end else begin
         trap_ff <= (trap_ff & trap_keep) | trap_set;
         if (!poa_ff) begin
            rdy_cnt_ff <= 13'h0000;
            not_ready_ff <= 1'b1;
         end else if (rdy_more) begin
            rdy_cnt_ff <= rdy_cnt_ff + 13'h0001;
         end else begin
            not_ready_ff <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   reg [7:0] rd_mux;
   always @* begin
      case (reg_addr_i)
         `LFS_A_STATUS: rd_mux = {7'h00, not_ready_ff};
         `LFS_A_PART_ID: rd_mux = PART_ID;
         `LFS_A_DIE_REV: rd_mux = DIE_REV;
         `LFS_A_OUT_CFG: rd_mux = out_cfg_ff;
         `LFS_A_BUS_ADDR: rd_mux = bus_addr_ff;
         `LFS_A_SHIFT_HI: rd_mux = shift_hi_ff;
         `LFS_A_SHIFT_LO: rd_mux = shift_lo_ff;
         `LFS_A_FMASK_LO: rd_mux = fmask_ff[7:0];
         `LFS_A_FMASK_HI: rd_mux = {6'h00, fmask_ff[9:8]};
         `LFS_A_SMASK_LO: rd_mux = smask_ff[7:0];
         `LFS_A_SMASK_HI: rd_mux = {7'h00, smask_ff[8]};
         `LFS_A_TRAP_LO: rd_mux = trap_ff[7:0];
         `LFS_A_TRAP_HI: rd_mux = {6'h00, trap_ff[9:8]};
         default: rd_mux = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   // Shutdown active when latched or supply below analog level
   wire shut_active = shut_ff | !poa_ff;
   wire pol = out_cfg_ff[`LFS_B_SHUT_POL];
   always @(posedge clock_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 8'h00;
         tx_fault_o <= 1'b1;
         safety_shutdown_out_o <= 1'b0;
         safety_shutdown_oe_o <= 1'b0;
         laser_swing_en_o <= 1'b0;
         bias_en_o <= 1'b0;
         bias_oe_o <= 1'b0;
         bus_dev_addr_o <= `LFS_BUS_ADDR_DEF;
      end else begin
         if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
         end
         tx_fault_o <= nxt_fault;
         // PMOS needs high to open, NMOS needs low
         safety_shutdown_out_o <= pol ? shut_active : !shut_active;
         safety_shutdown_oe_o <= recalled_ff;
         laser_swing_en_o <= nxt_out_en;
         bias_en_o <= nxt_out_en;
         bias_oe_o <= recalled_ff;
         bus_dev_addr_o <= recalled_ff ? bus_addr_ff : `LFS_BUS_ADDR_DEF;
      end
   end
endmodule

// ===== tb/lfs_switch.sv
// Shutdown switch, pull resistor and laser current on the far side
`timescale 1ns/1ps
module lfs_switch (
   input wire pull_high_i,
   input wire shut_oe_i,
   input wire shut_out_i,
   input wire swing_en_i,
   input wire bias_en_i,
   output wire pin_level_o,
   output wire laser_on_o
);
   // Undriven pin rests at the alarm level of the fitted resistor
   assign pin_level_o = shut_oe_i ? shut_out_i : pull_high_i;
   // Switch conducts only away from the alarm level
   assign laser_on_o = (pin_level_o != pull_high_i) && swing_en_i && bias_en_i;
endmodule

// ===== tb/lfs_top_asserts.sv
// Port checker of the fault and shutdown block
`timescale 1ns/1ps
module lfs_top_chk #(
   parameter [7:0] PART_ID = 8'h5A,
   parameter [7:0] DIE_REV = 8'h01
) (
   input wire clock_i,
   input wire nrst_i,
   input wire analog_power_ok_i,
   input wire tx_disable_pin_i,
   input wire adc_valid_i,
   input wire [2:0] adc_chan_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_rdata_o,
   input wire meas_valid_o,
   input wire [2:0] meas_chan_o,
   input wire tx_fault_o,
   input wire safety_shutdown_oe_o,
   input wire laser_swing_en_o,
   input wire bias_en_o,
   input wire [7:0] bus_dev_addr_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // ---------------------------------------------
   // Sequences
   // ---------------------------------------------
   // Long enough to cover the two-flop input sync
   sequence s_dis_on;
      (tx_disable_pin_i && analog_power_ok_i)[*5];
   endsequence
   sequence s_low;
      (!analog_power_ok_i)[*4];
   endsequence
   sequence s_conv;
      analog_power_ok_i[*4] ##0 adc_valid_i;
   endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   part_id_a: assert property (reg_rd_i && reg_addr_i == 8'h86 |=> reg_rdata_o == PART_ID)
      else $error("part id read wrong");
   die_rev_a: assert property (reg_rd_i && reg_addr_i == 8'h87 |=> reg_rdata_o == DIE_REV)
      else $error("die revision read wrong");
   meas_valid_a: assert property (s_conv |=> meas_valid_o)
      else $error("conversion not loaded");
   meas_chan_a: assert property (s_conv |=> meas_chan_o == $past(adc_chan_i))
      else $error("measurement channel wrong");
   dis_off_a: assert property (s_dis_on |-> !laser_swing_en_o && !bias_en_o)
      else $error("outputs on while disabled");
   dis_fault_a: assert property (s_dis_on |-> !tx_fault_o)
      else $error("fault high while disabled");
   low_fault_a: assert property (s_low |-> tx_fault_o)
      else $error("fault low at low supply");
   low_off_a: assert property (s_low |-> !laser_swing_en_o && !bias_en_o)
      else $error("outputs on at low supply");
   oe_rise_a: assert property ($rose(safety_shutdown_oe_o) |-> $past(analog_power_ok_i, 2))
      else $error("shutdown pin driven early");
   addr_def_a: assert property ($rose(nrst_i) |-> bus_dev_addr_o == 8'hA2)
      else $error("bus address not default");
endmodule

// ===== tb/lfs_top_bench.sv
// Self-checking bench of the fault and shutdown block
`timescale 1ns/1ps
module lfs_top_bench;
   localparam [7:0] PID = 8'h3C; // Arbitrary identity value
   localparam [7:0] REV = 8'h07; // Arbitrary identity value
   localparam [7:0] NVA = 8'hB4;
   reg clock_i = 1'b0;
   reg nrst_i = 1'b0;
   reg analog_power_ok = 1'b0, dis = 1'b0, adc_v = 1'b0, bupd = 1'b0, wr = 1'b0, rd = 1'b0, pull_hi = 1'b0, rd_seen = 1'b0;
   reg [2:0] adc_c = 3'h0, sa, sb, sc;
   reg [15:0] adc_d = 16'h0000, raw, re;
   reg [4:0] alm = 5'h00;
   reg [3:0] qt = 4'h0;
   reg [7:0] addr = 8'h00, wdat = 8'h00;
   reg [18:0] me;
   logic [15:0] rq[$];
   logic [18:0] mq[$];
   integer failures = 0, num_checks = 0, i, k, seed;
   wire [7:0] rdata, dev_a;
   wire [2:0] mc;
   wire [15:0] md;
   wire mv, flt, sd, sd_oe, swing, ben, boe, pin, laser;

   always #50 clock_i = ~clock_i;

   lfs_top #(.RDY_CYCLES(20), .PART_ID(PID), .DIE_REV(REV), .NV_BUS_ADDR(NVA)) i_dut (
      .clock_i(clock_i), .nrst_i(nrst_i), .analog_power_ok_i(analog_power_ok), .tx_disable_pin_i(dis),
      .adc_valid_i(adc_v), .adc_chan_i(adc_c), .adc_raw_i(adc_d), .vcc_low_limit_i(16'h8000),
      .adc_alarm_i(alm), .quick_trip_i(qt), .bias_update_i(bupd), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdata), .meas_valid_o(mv), .meas_chan_o(mc),
      .meas_data_o(md), .tx_fault_o(flt), .safety_shutdown_out_o(sd), .safety_shutdown_oe_o(sd_oe),
      .laser_swing_en_o(swing), .bias_en_o(ben), .bias_oe_o(boe), .bus_dev_addr_o(dev_a));
   lfs_switch i_sw (.pull_high_i(pull_hi), .shut_oe_i(sd_oe), .shut_out_i(sd), .swing_en_i(swing),
      .bias_en_i(ben), .pin_level_o(pin), .laser_on_o(laser));

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task chk(input string nm, input logic [18:0] e, input logic [18:0] g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clock_i);
   endtask
   task wreg(input [7:0] a, input [7:0] d);
      @(posedge clock_i);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task rreg(input [7:0] a, input [7:0] e, input [7:0] m);
      rq.push_back({m, e});
      @(posedge clock_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock_i);
      rd <= 1'b0;
   endtask
   task conv(input [2:0] c, input [15:0] d, input [15:0] e);
      mq.push_back({c, e});
      @(posedge clock_i);
      adc_v <= 1'b1;
      adc_c <= c;
      adc_d <= d;
      @(posedge clock_i);
      adc_v <= 1'b0;
   endtask
   task bias(input integer n);
      repeat (n) begin
         @(posedge clock_i);
         bupd <= 1'b1;
         @(posedge clock_i);
         bupd <= 1'b0;
      end
   endtask
   task results;
      chk("pending notes", 19'h0_0000, 19'(rq.size() + mq.size()));
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Result watcher, sampled mid-cycle
   // ---------------------------------------------
   always @(posedge clock_i) rd_seen <= rd;
   always @(negedge clock_i) begin
      if (rd_seen && rq.size() > 0) begin
         re = rq.pop_front();
         chk("read data", {11'h0, re[7:0] & re[15:8]}, {11'h0, rdata & re[15:8]});
      end
      if (mv && mq.size() > 0) begin
         me = mq.pop_front();
         chk("measurement", me, {mc, md});
      end
   end

   // Generous against roughly three hundred cycles of tests
   initial begin
      cyc(20000);
      failures = failures + 1;
      results;
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      seed = $urandom(48550);
      cyc(2);
      nrst_i <= 1'b1;
      cyc(3);
      chk("off state", 6'h20, {flt, sd_oe, pin, boe, swing, ben});
      chk("bus address", 8'hA2, dev_a);
      rreg(8'h6E, 8'h01, 8'h01);
      rreg(8'h86, PID, 8'hFF);
      rreg(8'h87, REV, 8'hFF);
      wreg(8'h86, 8'h00);
      rreg(8'h86, PID, 8'hFF);
      rreg(8'h3A, 8'h00, 8'hFF);
      $display("test ids done");
      analog_power_ok <= 1'b1;
      cyc(6);
      chk("bus address", NVA, dev_a);
      chk("pin drive", 2'b11, {sd_oe, pin});
      chk("held off", 2'b00, {swing, ben});
      cyc(20);
      rreg(8'h6E, 8'h00, 8'h01);
      conv(3'h1, 16'hC000, 16'hC000);
      bias(10);
      cyc(3);
      chk("enabled", 4'hF, {boe, swing, ben, laser});
      $display("test power up done");
      for (i = 0; i < 4; i = i + 1) begin
         sa = (i == 0) ? 3'h7 : 3'($urandom_range(7, 0));
         sb = 3'($urandom_range(7, 0));
         sc = 3'($urandom_range(7, 0));
         raw = 16'($urandom);
         wreg(8'h8E, {1'b0, sa, 1'b0, sb});
         wreg(8'h8F, {1'b0, sc, 4'h0});
         conv(3'h2, raw, raw >> sa);
         conv(3'h3, raw, raw >> sb);
         conv(3'h4, raw, raw >> sc);
      end
      $display("test shift done");
      wreg(8'h90, 8'h21);
      alm <= 5'h04;
      cyc(4);
      chk("fault", 1'b0, flt);
      alm <= 5'h05;
      cyc(4);
      chk("fault", 2'b11, {flt, swing});
      alm <= 5'h00;
      cyc(4);
      chk("fault", 1'b0, flt);
      wreg(8'h89, 8'h02);
      qt <= 4'h1;
      cyc(2);
      qt <= 4'h0;
      cyc(6);
      chk("fault", 1'b1, flt);
      wreg(8'h89, 8'h06);
      cyc(4);
      chk("fault", 1'b0, flt);
      rreg(8'h94, 8'h25, 8'h25);
      wreg(8'h94, 8'h00);
      rreg(8'h94, 8'h00, 8'h25);
      $display("test fault done");
      wreg(8'h89, 8'h00);
      wreg(8'h92, 8'h01);
      wreg(8'h91, 8'h02);
      for (k = 0; k < 2; k = k + 1) begin
         alm <= 5'h01;
         cyc(2);
         alm <= 5'h00;
         cyc(6);
         chk("tripped", 4'h8, {flt, pin, swing, ben});
         wreg(8'h89, 8'h04);
         cyc(4);
         chk("fault held", 1'b1, flt);
         if (k == 0) begin
            dis <= 1'b1;
            cyc(6);
         end else begin
            wreg(8'h89, 8'h08);
            cyc(4);
         end
         chk("released", 4'h4, {flt, pin, swing, ben});
         dis <= 1'b0;
         wreg(8'h89, 8'h00);
         bias(10);
         cyc(4);
         chk("reinit", 4'h7, {flt, pin, swing, ben});
      end
      rreg(8'h95, 8'h02, 8'h02);
      wreg(8'h95, 8'h00);
      rreg(8'h95, 8'h00, 8'h02);
      $display("test shutdown done");
      wreg(8'h89, 8'h01);
      pull_hi <= 1'b1;
      cyc(4);
      chk("pin level", 2'b01, {pin, laser});
      analog_power_ok <= 1'b0;
      cyc(5);
      chk("brownout", 4'hC, {flt, pin, swing, ben});
      rreg(8'h6E, 8'h01, 8'h01);
      rreg(8'h89, 8'h01, 8'h0F);
      analog_power_ok <= 1'b1;
      cyc(5);
      conv(3'h1, 16'hC000, 16'hC000);
      wreg(8'h91, 8'h03);
      qt <= 4'h1;
      cyc(4);
      chk("blanked", 1'b0, flt);
      qt <= 4'h8;
      cyc(4);
      chk("bias limit", 1'b1, flt);
      qt <= 4'h0;
      bias(10);
      cyc(4);
      chk("recovered", 3'h7, {laser, swing, ben});
      $display("test brownout done");
      nrst_i <= 1'b0;
      analog_power_ok <= 1'b0;
      cyc(2);
      nrst_i <= 1'b1;
      rreg(8'h89, 8'h00, 8'hFF);
      rreg(8'h94, 8'h00, 8'hFD);
      cyc(3);
      $display("test power cycle done");
      results;
   end
endmodule

bind lfs_top lfs_top_chk #(.PART_ID(PART_ID), .DIE_REV(DIE_REV)) i_chk (
   .clock_i(clock_i), .nrst_i(nrst_i), .analog_power_ok_i(analog_power_ok_i),
   .tx_disable_pin_i(tx_disable_pin_i), .adc_valid_i(adc_valid_i), .adc_chan_i(adc_chan_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .meas_valid_o(meas_valid_o),
   .meas_chan_o(meas_chan_o), .tx_fault_o(tx_fault_o), .safety_shutdown_oe_o(safety_shutdown_oe_o),
   .laser_swing_en_o(laser_swing_en_o), .bias_en_o(bias_en_o), .bus_dev_addr_o(bus_dev_addr_o));
